// File: hdl/cep_regs.svh
// Constants for the configuration memory programming port.
// Assumes inclusion wherever these constants are needed.
`ifndef CEP_REGS_SVH
`define CEP_REGS_SVH
`define CEP_NUM_BYTES     13
`define CEP_BYTE_BITS     8
`define CEP_INIT_PULSES   1500
`define CEP_CLK_PERIOD_NS 5
`define CEP_PROG_MIN_NS   2000
`define CEP_PTR_W         4
`define CEP_MEM_RESET     8'h00
// Pin level codes: two comparator flags per key.
`define CEP_LVL_GND       2'h0
`define CEP_LVL_RW        2'h1
`define CEP_LVL_SV        2'h3
`endif

// File: hdl/cep_pkg.sv
// Types for the configuration memory programming port.
// Assumes nothing beyond the constants header.
`include "cep_regs.svh"
package cep_pkg;
  typedef enum logic [2:0] {
    CEP_INIT    = 3'h0,
    CEP_IDLE    = 3'h1,
    CEP_WSEQ1   = 3'h2,
    CEP_WSEQ2   = 3'h3,
    CEP_WSEQ3   = 3'h4,
    CEP_RSEQ1   = 3'h5,
    CEP_WRITE   = 3'h6,
    CEP_READ    = 3'h7
  } cep_state_t;
  typedef logic [1:0] cep_level_t;
endpackage

// File: hdl/cep_sync_if.sv
// Interface carrying synchronised pin levels between the modules.
// Assumes one clock domain.
`timescale 1ns/1ps
interface cep_sync_if;
  logic [1:0] selLevel;
  logic [1:0] strobeLevel;
  logic       serialClk;
  modport src (output selLevel, output strobeLevel, output serialClk);
  modport dst (input selLevel, input strobeLevel, input serialClk);
endinterface

// File: hdl/cep_pin_sync.sv
// Two-stage synchronisers for the key level flags and the serial clock.
// Assumes asynchronous pins and one system clock.
`timescale 1ns/1ps
`include "cep_regs.svh"
module cep_pin_sync (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Raw pins
  input  wire logic [1:0] selRaw,
  input  wire logic [1:0] strobeRaw,
  input  wire logic       clkRaw,
  // Synchronised outputs
  cep_sync_if.src         syncOut
);
  logic [4:0] stage1_reg;
  logic [4:0] stage2_reg;

  // The first stage feeds only the second; logic reads stage two.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stage1_reg <= 5'h00;
      stage2_reg <= 5'h00;
    end else begin
      stage1_reg <= {clkRaw, strobeRaw, selRaw};
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut.selLevel    = stage2_reg[1:0];
  assign syncOut.strobeLevel = stage2_reg[3:2];
  assign syncOut.serialClk   = stage2_reg[4];
endmodule

// File: hdl/cep_program_port.sv
// Programming port for the 13-byte nonvolatile configuration memory.
// Assumes key pins arrive as level-comparator flags (bit0 above ground,
// bit1 at supervoltage) and the serial clock is far slower than mclk.
`timescale 1ns/1ps
`include "cep_regs.svh"
module cep_program_port #(
  parameter int NUM_BYTES   = `CEP_NUM_BYTES,
  parameter int INIT_PULSES = `CEP_INIT_PULSES
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Key pins as level flags
  input  wire logic [1:0] firstKeySelect,
  input  wire logic [1:0] secondKeyStrobe,
  // Serial clock pin
  input  wire logic       clockInputPin,
  // Transmit pin and memory view
  output logic            txData,
  output logic            writeMode,
  output logic            readMode,
  output logic [7:0]      memData [NUM_BYTES]
);
  localparam int PW = `CEP_PTR_W;

  // All checks below sample on mclk and pause while reset is held.
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);

  cep_sync_if sync ();
  cep_pin_sync cep_pin_sync_inst (
    .mclk      (mclk),
    .rst       (rst),
    .selRaw    (firstKeySelect),
    .strobeRaw (secondKeyStrobe),
    .clkRaw    (clockInputPin),
    .syncOut   (sync.src)
  );

  cep_pkg::cep_state_t state_reg;
  logic              clkPrev_reg;
  logic [10:0]       initCnt_reg;
  logic [PW-1:0]     ptr_reg;
  logic [2:0]        bitCnt_reg;
  logic [7:0]        shift_reg;
  logic              selPrev_reg;
  logic [7:0]        mem_reg [NUM_BYTES];
  logic              clkRise;
  logic              selSv;
  logic              selRw;
  logic              strSv;
  logic              strRw;
  logic              bothGnd;
  logic              selFall;

  // Decodes a pin level code against a wanted level.
  function automatic logic isLevel(input cep_pkg::cep_level_t lv,
                                   input cep_pkg::cep_level_t want);
    isLevel = (lv == want);
  endfunction

  // Next byte index, clamped to the last byte.
  function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
    nextPtr = (p == PW'(NUM_BYTES - 1)) ? p : p + PW'(1);
  endfunction

  // Strobe data bit: any level above ground counts as a one.
  function automatic logic secondKeyStrobeBit(input cep_pkg::cep_level_t lv);
    secondKeyStrobeBit = lv[0];
  endfunction

  // Level decode of the synchronised pins.
  assign selSv   = isLevel(sync.selLevel, `CEP_LVL_SV);
  assign selRw   = isLevel(sync.selLevel, `CEP_LVL_RW);
  assign strSv   = isLevel(sync.strobeLevel, `CEP_LVL_SV);
  assign strRw   = isLevel(sync.strobeLevel, `CEP_LVL_RW);
  assign bothGnd = isLevel(sync.selLevel, `CEP_LVL_GND) &&
                   isLevel(sync.strobeLevel, `CEP_LVL_GND);
  assign clkRise = sync.serialClk && !clkPrev_reg;
  assign selFall = selPrev_reg && selRw;

  // Edge history of the serial clock and the select level.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clkPrev_reg <= 1'b0;
      selPrev_reg <= 1'b0;
    end else begin
      clkPrev_reg <= sync.serialClk;
      selPrev_reg <= selSv;
    end
  end

  // ----------------------------------------------------------------
  // Power-up pulse count and mode sequencing
  // ----------------------------------------------------------------
  // Counting the pulses here means early entry attempts are ignored
  // rather than corrupting the sequencer.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      initCnt_reg <= 11'h000;
    end else if (clkRise && initCnt_reg != 11'(INIT_PULSES)) begin
      initCnt_reg <= initCnt_reg + 11'h001;
    end
  end

  // supervoltage gated entry
  // Every entry sequence into a mode starts with a key at supervoltage; the final step into a mode needs both keys at read/write.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= cep_pkg::CEP_INIT;
    end else begin
      case (state_reg)
        cep_pkg::CEP_INIT: begin
          if (initCnt_reg == 11'(INIT_PULSES)) begin
            state_reg <= cep_pkg::CEP_IDLE;
          end
        end
        cep_pkg::CEP_IDLE: begin
          if (strSv && selRw) begin
            state_reg <= cep_pkg::CEP_WSEQ1;
          end else if (selSv && strRw) begin
            state_reg <= cep_pkg::CEP_RSEQ1;
          end
        end
        cep_pkg::CEP_WSEQ1: begin
          if (strSv && selSv) begin
            state_reg <= cep_pkg::CEP_WSEQ2;
          end else if (!strSv) begin
            state_reg <= cep_pkg::CEP_IDLE;
          end
        end
        cep_pkg::CEP_WSEQ2: begin
          if (strRw && selSv) begin
            state_reg <= cep_pkg::CEP_WSEQ3;
          end else if (!(strSv && selSv)) begin
            state_reg <= cep_pkg::CEP_IDLE;
          end
        end
        cep_pkg::CEP_WSEQ3: begin
          if (strRw && selRw) begin
            state_reg <= cep_pkg::CEP_WRITE;
          end else if (!(strRw && selSv)) begin
            state_reg <= cep_pkg::CEP_IDLE;
          end
        end
        cep_pkg::CEP_RSEQ1: begin
          if (selRw && strRw) begin
            state_reg <= cep_pkg::CEP_READ;
          end else if (!(selSv && strRw)) begin
            state_reg <= cep_pkg::CEP_IDLE;
          end
        end
        cep_pkg::CEP_WRITE, cep_pkg::CEP_READ: begin
          if (bothGnd) begin
            state_reg <= cep_pkg::CEP_IDLE;
          end
        end
        default: state_reg <= cep_pkg::CEP_IDLE;
      endcase
    end
  end

  assign writeMode = (state_reg == cep_pkg::CEP_WRITE);
  assign readMode  = (state_reg == cep_pkg::CEP_READ);

  // ----------------------------------------------------------------
  // Serial data path
  // ----------------------------------------------------------------
  // pointer control
  // The pointer is cleared whenever no mode is active, so entry starts
  // at byte zero; it saturates at the last byte.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ptr_reg    <= '0;
      bitCnt_reg <= 3'h0;
      shift_reg  <= 8'h00;
    end else if (!writeMode && !readMode) begin
      ptr_reg    <= '0;
      bitCnt_reg <= 3'h0;
      shift_reg  <= mem_reg[0];
    end else if (writeMode) begin
      if (selSv && clkRise) begin
        shift_reg  <= {secondKeyStrobeBit(sync.strobeLevel), shift_reg[7:1]};
        bitCnt_reg <= bitCnt_reg + 3'h1;
      end else if (selFall) begin
        ptr_reg    <= nextPtr(ptr_reg);
        bitCnt_reg <= 3'h0;
      end
    end else begin
      if (selSv && clkRise) begin
        bitCnt_reg <= bitCnt_reg + 3'h1;
        if (bitCnt_reg == 3'h7) begin
          ptr_reg   <= nextPtr(ptr_reg);
          shift_reg <= mem_reg[nextPtr(ptr_reg)];
        end else begin
          shift_reg <= {shift_reg[6:0], 1'b0};
        end
      end
    end
  end

  // store on select return
  // The byte is committed when the bit count is back at zero, after eight bits or none; a short
  // byte is dropped but the pointer still advances.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_BYTES; i++) begin
        mem_reg[i] <= `CEP_MEM_RESET;
      end
    end else if (writeMode && selFall && bitCnt_reg == 3'h0) begin
      mem_reg[ptr_reg] <= shift_reg;
    end
  end

  // output pin
  // Read mode drives the current MSB; write mode pulls low on every select return, stored or not.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      txData <= 1'b1;
    end else if (readMode) begin
      txData <= shift_reg[7];
    end else if (writeMode) begin
      txData <= !(selFall || (!selSv && !txData));
    end else begin
      txData <= 1'b1;
    end
  end

  assign memData = mem_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_no_mode_early: assert property (
    (initCnt_reg != 11'(INIT_PULSES)) |-> !writeMode && !readMode)
    else $error("Mode entered before power-up pulses.");
  a_write_entry_order: assert property (
    $rose(writeMode) |-> $past(state_reg) == cep_pkg::CEP_WSEQ3)
    else $error("Write mode entered out of order.");
  a_read_entry_order: assert property (
    $rose(readMode) |-> $past(state_reg) == cep_pkg::CEP_RSEQ1)
    else $error("Read mode entered out of order.");
  a_ground_exit: assert property (
    (writeMode || readMode) && bothGnd |=> state_reg == cep_pkg::CEP_IDLE)
    else $error("Mode not left on ground.");
  a_write_done_low: assert property (
    writeMode && selFall && !bothGnd |=> !txData)
    else $error("Write completion not shown.");
  a_ptr_entry_zero: assert property (
    $rose(writeMode) || $rose(readMode) |-> ptr_reg == '0)
    else $error("Pointer not at first byte.");
  a_read_msb_out: assert property (
    readMode && !bothGnd |=> txData == $past(shift_reg[7]))
    else $error("Read output not MSB.");
  a_ptr_bound: assert property (
    ptr_reg < PW'(NUM_BYTES))
    else $error("Pointer past last byte.");
  a_shift_edge: assert property (
    writeMode && !clkRise && !selFall |=> $stable(bitCnt_reg))
    else $error("Bit latched without clock edge.");
  a_sv_entry: assert property (
    $rose(state_reg == cep_pkg::CEP_RSEQ1) |-> $past(selSv))
    else $error("Read entry without supervoltage.");

  c_write_mode: cover property ($rose(writeMode));
  c_read_mode: cover property ($rose(readMode));
  c_byte_store: cover property (writeMode && selFall && bitCnt_reg == 3'h0);
  c_stream_next: cover property (
    readMode && clkRise && selSv && bitCnt_reg == 3'h7);

  // The minimum programming clock period is met by the programmer; the
  // sampling here only needs a few mclk cycles per serial clock phase.
endmodule

// File: bench/cep_programmer_model.sv
// Behavioural programmer driving the key levels and the serial clock.
// Assumes a 200 MHz mclk and that the bench calls its tasks in order.
`timescale 1ns/1ps
`include "cep_regs.svh"
module cep_programmer_model #(
  parameter int HALF_CYC = 200
) (
  // Clock
  input  wire logic          mclk,
  // Pins toward the device
  output cep_pkg::cep_level_t selLvl,
  output cep_pkg::cep_level_t strobeLvl,
  output logic                serClk
);
  // Keys idle at the read/write level; the clock stands low between frames.
  initial begin
    selLvl = `CEP_LVL_RW;
    strobeLvl = `CEP_LVL_RW;
    serClk = 1'h0;
  end

  // key ordering
  // Each level is held for eight cycles so the synchroniser sees it.
  task automatic keys(input cep_pkg::cep_level_t s,
                      input cep_pkg::cep_level_t d);
    @(negedge mclk);
    selLvl = s;
    strobeLvl = d;
    repeat (8) @(negedge mclk);
  endtask

  // slow serial pulse
  // Data is set up a quarter period before the rise and held past the
  // fall; the period of 2 * HALF_CYC cycles is 2000 ns at the default,
  // the fastest legal pace, which keeps a full run within its limit.
  task automatic pulse(input logic bitVal);
    @(negedge mclk);
    strobeLvl = bitVal ? `CEP_LVL_RW : `CEP_LVL_GND;
    repeat (HALF_CYC / 2) @(negedge mclk);
    serClk = 1'h1;
    repeat (HALF_CYC) @(negedge mclk);
    serClk = 1'h0;
    repeat (HALF_CYC / 2) @(negedge mclk);
  endtask
endmodule

// File: bench/config_eeprom_program_port_bench.sv
// Self-checking bench for the configuration memory programming port.
// Assumes the programmer model and the design files are compiled first.
`timescale 1ns/1ps
`include "cep_regs.svh"
module config_eeprom_program_port_bench;
  localparam int NB = `CEP_NUM_BYTES;
  typedef struct {
    int         sel;
    logic [7:0] val;
  } cep_note_t;
  logic                mclk;
  logic                rst;
  cep_pkg::cep_level_t selLvl;
  cep_pkg::cep_level_t strobeLvl;
  logic                serClk;
  logic                txData;
  logic                writeMode;
  logic                readMode;
  logic [7:0]          memData [NB];
  logic [7:0]          data [NB];
  logic [7:0]          got;
  cep_note_t           cur;
  cep_note_t           expQ [$];
  event                look;
  int                  badCount = 0;
  int                  samplesChecked = 0;
  int                  seed = 32;
  int                  i;
  int                  b;

  cep_program_port #(.NUM_BYTES(NB), .INIT_PULSES(4)) cep_program_port_inst (
    .mclk(mclk), .rst(rst), .firstKeySelect(selLvl),
    .secondKeyStrobe(strobeLvl), .clockInputPin(serClk), .txData(txData),
    .writeMode(writeMode), .readMode(readMode), .memData(memData));

  cep_programmer_model cep_programmer_model_inst (
    .mclk(mclk), .selLvl(selLvl), .strobeLvl(strobeLvl), .serClk(serClk));

  // Free-running 200 MHz clock.
  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end

  // Compares one value and counts it.
  task automatic check(input int sel, input logic [7:0] seen,
                       input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected %s expected %h seen %h", sel == 0 ? "txData" :
               sel == 1 ? "writeMode" : sel == 2 ? "readMode" : "memData",
               exp, seen);
    end
  endtask

  // Queues an expectation and wakes the watcher; the delay keeps one
  // wake-up per note so none is lost.
  task automatic note(input int sel, input logic [7:0] val);
    expQ.push_back('{sel, val});
    ->look;
    #1;
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic closeOut;
    $display("checked %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watcher: takes the oldest note and samples the matching output.
  initial forever begin
    @(look);
    cur = expQ.pop_front();
    case (cur.sel)
      0: got = {7'h00, txData};
      1: got = {7'h00, writeMode};
      2: got = {7'h00, readMode};
      default: got = memData[cur.sel - 3];
    endcase
    check(cur.sel, got, cur.val);
  end

  // Hang guard: the full run needs about 427 us, not far under this time.
  initial begin
    #500000;
    badCount++;
    closeOut();
  end

  // Main sequence; all pin changes happen at the falling edge.
  initial begin
    rst = 1'h1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    rst = 1'h0;
    @(negedge mclk);
    note(0, 8'h01);
    note(1, 8'h00);
    note(2, 8'h00);
    $display("test reset done");
    cep_programmer_model_inst.keys(`CEP_LVL_RW, `CEP_LVL_SV);
    cep_programmer_model_inst.keys(`CEP_LVL_SV, `CEP_LVL_SV);
    cep_programmer_model_inst.keys(`CEP_LVL_SV, `CEP_LVL_RW);
    cep_programmer_model_inst.keys(`CEP_LVL_RW, `CEP_LVL_RW);
    note(1, 8'h00);
    for (i = 0; i < 4; i++) cep_programmer_model_inst.pulse(1'h1);
    cep_programmer_model_inst.keys(`CEP_LVL_RW, `CEP_LVL_SV);
    cep_programmer_model_inst.keys(`CEP_LVL_SV, `CEP_LVL_SV);
    cep_programmer_model_inst.keys(`CEP_LVL_RW, `CEP_LVL_SV);
    cep_programmer_model_inst.keys(`CEP_LVL_RW, `CEP_LVL_RW);
    note(1, 8'h00);
    $display("test refused entry done");
    cep_programmer_model_inst.keys(`CEP_LVL_RW, `CEP_LVL_SV);
    cep_programmer_model_inst.keys(`CEP_LVL_SV, `CEP_LVL_SV);
    cep_programmer_model_inst.keys(`CEP_LVL_SV, `CEP_LVL_RW);
    cep_programmer_model_inst.keys(`CEP_LVL_RW, `CEP_LVL_RW);
    note(1, 8'h01);
    for (i = 0; i < NB; i++) begin
      data[i] = 8'($random(seed));
      cep_programmer_model_inst.keys(`CEP_LVL_SV, `CEP_LVL_RW);
      for (b = 0; b < 8; b++) cep_programmer_model_inst.pulse(data[i][b]);
      cep_programmer_model_inst.keys(`CEP_LVL_RW, `CEP_LVL_RW);
      for (b = 0; b < 16 && txData !== 1'h0; b++) @(negedge mclk);
      note(0, 8'h00);
    end
    cep_programmer_model_inst.keys(`CEP_LVL_GND, `CEP_LVL_GND);
    note(1, 8'h00);
    for (i = 0; i < NB; i++) note(3 + i, data[i]);
    $display("test write done");
    cep_programmer_model_inst.keys(`CEP_LVL_RW, `CEP_LVL_RW);
    cep_programmer_model_inst.keys(`CEP_LVL_SV, `CEP_LVL_RW);
    cep_programmer_model_inst.keys(`CEP_LVL_RW, `CEP_LVL_RW);
    note(2, 8'h01);
    cep_programmer_model_inst.keys(`CEP_LVL_SV, `CEP_LVL_RW);
    for (i = 0; i < NB; i++) begin
      for (b = 7; b >= 0; b--) begin
        // Each bit stands before its own pulse; the rise moves to the next.
        note(0, {7'h00, data[i][b]});
        cep_programmer_model_inst.pulse(1'h1);
      end
    end
    cep_programmer_model_inst.keys(`CEP_LVL_RW, `CEP_LVL_RW);
    cep_programmer_model_inst.keys(`CEP_LVL_GND, `CEP_LVL_GND);
    note(2, 8'h00);
    $display("test read done");
    closeOut();
  end
endmodule
